// ### bench/hts_assertions.sv
`timescale 1ns/10ps
`include "hts_consts.svh"

// ------------------------------
// port checker
// ------------------------------
module hts_chk (
  input logic        CLK,
  input logic        RESET_N,
  input logic [7:0]  ADDR,
  input logic [31:0] WR_DATA,
  input logic        WR_STB,
  input logic [31:0] RD_DATA,
  input logic        RD_STB,
  input logic        HOP_PIN,
  input logic [31:0] CARRIER_FREQ,
  input logic [31:0] OSC0_FREQ,
  input logic        RETUNE_PULSE,
  input logic        HOP_PULSE,
  input logic [1:0]  CUR_ASSIGN,
  input logic [1:0]  NEXT_ASSIGN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  property p_rd_zero;
    !$past(RD_STB) |-> RD_DATA == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_hop_cause;
    HOP_PULSE |-> $past(WR_STB && ADDR == `HTS_OFF_COMMIT) || $past(HOP_PIN, 2);
  endproperty
  a_hop_cause: assert property (p_hop_cause) else $error("hop without cause");
  property p_retune_one;
    RETUNE_PULSE |=> !RETUNE_PULSE;
  endproperty
  a_retune_one: assert property (p_retune_one) else $error("retune pulse too long");
  property p_commit_next;
    HOP_PULSE && $past(WR_STB && ADDR == `HTS_OFF_COMMIT) |-> NEXT_ASSIGN == $past(WR_DATA[1:0]);
  endproperty
  a_commit_next: assert property (p_commit_next) else $error("commit not on frame after next");
  property p_cur_from_next;
    HOP_PULSE |-> CUR_ASSIGN == $past(NEXT_ASSIGN);
  endproperty
  a_cur_from_next: assert property (p_cur_from_next) else $error("current frame not old next");
  property p_plain_next;
    HOP_PULSE && !$past(WR_STB && ADDR == `HTS_OFF_COMMIT) |-> NEXT_ASSIGN == 2'h0;
  endproperty
  a_plain_next: assert property (p_plain_next) else $error("pin hop kept next");
  property p_retune_osc;
    RETUNE_PULSE |-> OSC0_FREQ == CARRIER_FREQ;
  endproperty
  a_retune_osc: assert property (p_retune_osc) else $error("osc not retuned");
  property p_assign_hold;
    !HOP_PULSE |-> $stable(NEXT_ASSIGN) && $stable(CUR_ASSIGN);
  endproperty
  a_assign_hold: assert property (p_assign_hold) else $error("assignment moved off hop");
endmodule

bind hts_top hts_chk hts_chk_inst (.CLK, .RESET_N, .ADDR, .WR_DATA, .WR_STB, .RD_DATA, .RD_STB,
  .HOP_PIN, .CARRIER_FREQ, .OSC0_FREQ, .RETUNE_PULSE, .HOP_PULSE, .CUR_ASSIGN, .NEXT_ASSIGN);

// ### bench/hts_hop_drv.sv
`timescale 1ns/10ps

// ------------------------------
// far side hop driver
// ------------------------------
module hts_hop_drv (
  input  logic       clk,
  input  logic       go,
  input  logic [2:0] idx,
  output logic       hop_pin,
  output logic [2:0] gp_pins
);
  int cnt = 0;

  initial begin
    hop_pin = 1'b0;
    gp_pins = 3'h0;
  end

  // index settles before the edge; long high and low keep the synchroniser safe
  always @(posedge clk) begin
    if (go && cnt == 0) begin
      gp_pins <= idx;
      cnt <= 12;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      hop_pin <= (cnt > 2 && cnt < 11);
    end
  end
endmodule

// ### bench/test_hop_table_sequencer.sv
`timescale 1ns/10ps
`include "hts_consts.svh"

module test_hop_table_sequencer;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WR_DATA = 32'h0;
  logic        WR_STB = 1'b0;
  logic        RD_STB = 1'b0;
  logic        go = 1'b0;
  logic [2:0]  idx = 3'h0;
  logic [31:0] RD_DATA, CARRIER_FREQ, RX1_OFFSET, RX2_OFFSET, OSC0_FREQ, OSC1_FREQ, rd_val;
  logic [7:0]  RX1_GAIN, RX2_GAIN;
  logic [15:0] TX_ATTEN;
  logic        HOP_PIN, OSC_SEL, RETUNE_PULSE, HOP_PULSE, osc;
  logic [2:0]  DIGITAL_GP_PINS;
  logic [1:0]  CUR_ASSIGN, NEXT_ASSIGN, prev;
  int          errors = 0;
  int          checks_done = 0;
  int          n;
  // ------------------------------
  // rows: {commit bits, expected carrier}
  // ------------------------------
  logic [33:0] rows [8] = '{34'h2_1000_0001, 34'h1_1000_0002, 34'h2_1000_0003, 34'h3_2000_0000,
                           34'h2_2000_0001, 34'h1_2000_0002, 34'h2_2000_0003, 34'h1_1000_0000};

  always #5 CLK = ~CLK;

  hts_top hts_top_inst (.CLK, .RESET_N, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA, .HOP_PIN,
    .DIGITAL_GP_PINS, .CARRIER_FREQ, .RX1_OFFSET, .RX2_OFFSET, .RX1_GAIN, .RX2_GAIN, .TX_ATTEN,
    .OSC0_FREQ, .OSC1_FREQ, .OSC_SEL, .RETUNE_PULSE, .HOP_PULSE, .CUR_ASSIGN, .NEXT_ASSIGN);
  hts_hop_drv hts_hop_drv_inst (.clk(CLK), .go, .idx, .hop_pin(HOP_PIN), .gp_pins(DIGITAL_GP_PINS));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // gap cycle after each write keeps the strobe from being driven twice at one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1 rd_val = RD_DATA;
    @(posedge CLK);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    #1 chk("carrier", 32'h0, CARRIER_FREQ);
    @(posedge CLK);
    rd(8'h40);
    chk("unmapped", 32'h0, rd_val);
    wr(`HTS_OFF_COMMIT, 32'h3);
    chk("idle commit", 32'h0, {30'h0, NEXT_ASSIGN});
    for (int e = 0; e < 8; e++) begin
      wr(`HTS_OFF_SEL, {28'h0, e[2], 1'b0, e[1:0]});
      wr(`HTS_OFF_CARRIER, {2'h0, e[2], !e[2], 26'h0, e[1:0]});
    end
    wr(`HTS_OFF_SEL, 32'h0);
    wr(`HTS_OFF_RX1_OFS, 32'h111);
    wr(`HTS_OFF_RX2_OFS, 32'h222);
    wr(`HTS_OFF_GAINS, 32'hABCD_1234);
    rd(`HTS_OFF_CARRIER);
    chk("carrier reg", 32'h1000_0000, rd_val);
    wr(`HTS_OFF_LEN, 32'h33);
    wr(`HTS_OFF_CTRL, 32'h71);
    for (n = 0; n < 40 && CARRIER_FREQ !== 32'h1000_0000; n++) begin
      @(posedge CLK);
      #1;
    end
    chk("start", 32'h1000_0000, CARRIER_FREQ);
    chk("offsets", 32'h111_0222, {RX1_OFFSET[15:0], RX2_OFFSET[15:0]});
    chk("gains", 32'hABCD_1234, {TX_ATTEN, RX2_GAIN, RX1_GAIN});
    @(posedge CLK);
    prev = 2'h0;
    for (int r = 0; r < 8; r++) begin
      osc = OSC_SEL;
      wr(`HTS_OFF_COMMIT, {30'h0, rows[r][33:32]});
      chk("hop carrier", rows[r][31:0], CARRIER_FREQ);
      chk("cur", {30'h0, prev}, {30'h0, CUR_ASSIGN});
      chk("next", {30'h0, rows[r][33:32]}, {30'h0, NEXT_ASSIGN});
      chk("osc swap", {31'h0, !osc}, {31'h0, OSC_SEL});
      chk("osc freq", rows[r][31:0], OSC_SEL ? OSC1_FREQ : OSC0_FREQ);
      prev = rows[r][33:32];
    end
    // ------------------------------
    // pin hops, gpio index, retune
    // ------------------------------
    wr(`HTS_OFF_CTRL, 32'h0);
    wr(`HTS_OFF_CTRL, 32'h7A);
    for (n = 0; n < 20 && rd_val[9] !== 1'b1; n++) rd(`HTS_OFF_STATUS);
    osc = OSC_SEL;
    for (int g = 2; g > 0; g--) begin
      idx <= g[2:0];
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      for (n = 0; n < 30 && HOP_PULSE !== 1'b1; n++) begin
        @(posedge CLK);
        #1;
      end
      @(posedge CLK);
      #1 chk("gpio carrier", 32'h1000_0000 | g, CARRIER_FREQ);
      chk("pin next", 32'h0, {30'h0, NEXT_ASSIGN});
      chk("pin cur", {30'h0, prev}, {30'h0, CUR_ASSIGN});
      chk("one osc", {31'h0, osc}, {31'h0, OSC_SEL});
      chk("retune freq", 32'h1000_0000 | g, OSC0_FREQ);
      chk("retune pulse", 32'h1, {31'h0, RETUNE_PULSE});
      prev = 2'h0;
      // driver must count out its pulse before it takes the next go
      repeat (8) @(posedge CLK);
    end
    // ------------------------------
    // loop on the only loaded table, real-time mode
    // ------------------------------
    wr(`HTS_OFF_CTRL, 32'h0);
    wr(`HTS_OFF_CTRL, 32'h54);
    repeat (2) @(posedge CLK);
    for (int r = 1; r < 5; r++) begin
      osc = OSC_SEL;
      wr(`HTS_OFF_COMMIT, 32'h3);
      #1 chk("loop carrier", 32'h2000_0000 | (r % 4), CARRIER_FREQ);
      chk("rt freq", 32'h2000_0000 | (r % 4), OSC_SEL ? OSC1_FREQ : OSC0_FREQ);
      chk("rt swap", {31'h0, !osc}, {31'h0, OSC_SEL});
    end
    // ------------------------------
    // reset in mid-run
    // ------------------------------
    RESET_N <= 1'b0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    #1 chk("reset assign", 32'h0, {28'h0, CUR_ASSIGN, NEXT_ASSIGN});
    chk("reset carrier", 32'h0, CARRIER_FREQ);
    chk("reset osc sel", 32'h0, {31'h0, OSC_SEL});
    tally_and_finish();
  end
endmodule

// ### rtl/hts_consts.svh
`ifndef HTS_CONSTS_SVH
`define HTS_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define HTS_OFF_CTRL      8'h00
`define HTS_OFF_LEN       8'h04
`define HTS_OFF_SEL       8'h08
`define HTS_OFF_CARRIER   8'h0C
`define HTS_OFF_RX1_OFS   8'h10
`define HTS_OFF_RX2_OFS   8'h14
`define HTS_OFF_GAINS     8'h18
`define HTS_OFF_COMMIT    8'h1C
`define HTS_OFF_STATUS    8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define HTS_CTRL_OP_LSB   0
`define HTS_CTRL_OSC_LSB  2
`define HTS_CTRL_EN       4
`define HTS_CTRL_LD_FIRST 5
`define HTS_CTRL_LD_SEC   6
`define HTS_CTRL_TBL      7
`define HTS_LEN_SEC_LSB   4
`define HTS_SEL_TBL       3
`define HTS_COMMIT_RX     0
`define HTS_COMMIT_TX     1

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define HTS_CTRL_RST      8'h00
`define HTS_LEN_RST       7'h00
`define HTS_SEL_RST       4'h0
`define HTS_IDX_W         3
`define HTS_ENTRIES       16

`endif

// ### rtl/hts_pkg.sv
package hts_pkg;

  typedef enum logic [1:0] {HTS_OP_LOOP, HTS_OP_PINGPONG, HTS_OP_GPIO, HTS_OP_RSVD} hts_op_t;

  typedef enum logic [1:0] {HTS_OSC_PREPROC, HTS_OSC_REALTIME, HTS_OSC_RETUNE, HTS_OSC_RSVD} hts_osc_t;

  typedef enum logic [1:0] {HTS_IDLE, HTS_PREP, HTS_RUN, HTS_PROC} hts_state_t;

  typedef struct packed {
    logic [31:0] carrier;
    logic [31:0] rx1_ofs;
    logic [31:0] rx2_ofs;
    logic [7:0]  rx1_gain;
    logic [7:0]  rx2_gain;
    logic [15:0] tx_atten;
  } hts_entry_t;

endpackage

// ### rtl/hts_sync.sv
`timescale 1ns/10ps

module hts_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ### rtl/hts_top.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "hts_consts.svh"

module hts_top (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [31:0] RD_DATA,
  input  wire logic        HOP_PIN,
  input  wire logic [2:0]  DIGITAL_GP_PINS,
  output logic      [31:0] CARRIER_FREQ,
  output logic      [31:0] RX1_OFFSET,
  output logic      [31:0] RX2_OFFSET,
  output logic      [7:0]  RX1_GAIN,
  output logic      [7:0]  RX2_GAIN,
  output logic      [15:0] TX_ATTEN,
  output logic      [31:0] OSC0_FREQ,
  output logic      [31:0] OSC1_FREQ,
  output logic             OSC_SEL,
  output logic             RETUNE_PULSE,
  output logic             HOP_PULSE,
  output logic      [1:0]  CUR_ASSIGN,
  output logic      [1:0]  NEXT_ASSIGN
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pins_s;
  logic       hop_d_r;

  hts_sync #(.W(4)) u_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .d       ({HOP_PIN, DIGITAL_GP_PINS}),
    .q       (pins_s)
  );

  // ----------------------------------------
  // registers and table storage
  // ----------------------------------------
  hts_pkg::hts_entry_t mem [`HTS_ENTRIES];

  logic [7:0]  ctrl_r,     ctrl_nxt;
  logic [6:0]  len_r,      len_nxt;
  logic [3:0]  sel_r,      sel_nxt;
  logic [3:0]  pos_r,      pos_nxt;
  logic [4:0]  prep_r,     prep_nxt;
  logic [1:0]  cur_r,      cur_nxt;
  logic [1:0]  next_r,     next_nxt;
  logic [31:0] osc0_r,     osc0_nxt;
  logic [31:0] osc1_r,     osc1_nxt;
  logic        sel_osc_r,  sel_osc_nxt;
  logic        retune_r,   retune_nxt;
  logic        hop_p_r,    hop_p_nxt;
  logic [31:0] rd_r,       rd_nxt;
  hts_pkg::hts_entry_t     app_r, app_nxt;
  hts_pkg::hts_state_t     st_r,  st_nxt;

  hts_pkg::hts_op_t  op;
  hts_pkg::hts_osc_t osc_mode;
  logic              en, ld_a, ld_b, run_tbl;
  logic [2:0]        last_a, last_b, cur_last;
  logic [4:0]        total;
  logic [3:0]        np;
  logic              hop_edge, commit_wr, hop_ev;
  hts_pkg::hts_entry_t ent;

  assign op       = hts_pkg::hts_op_t'(ctrl_r[`HTS_CTRL_OP_LSB +: 2]);
  assign osc_mode = hts_pkg::hts_osc_t'(ctrl_r[`HTS_CTRL_OSC_LSB +: 2]);
  assign en       = ctrl_r[`HTS_CTRL_EN];
  assign ld_a     = ctrl_r[`HTS_CTRL_LD_FIRST];
  assign ld_b     = ctrl_r[`HTS_CTRL_LD_SEC];
  assign last_a   = len_r[2:0];
  assign last_b   = len_r[`HTS_LEN_SEC_LSB +: 3];
  assign cur_last = pos_r[3] ? last_b : last_a;
  // falls back to whichever table is loaded
  assign run_tbl  = ctrl_r[`HTS_CTRL_TBL] ? (ld_b | ~ld_a) : (ld_b & ~ld_a);
  assign total    = (ld_a ? {2'h0, last_a} + 5'h01 : 5'h00) + (ld_b ? {2'h0, last_b} + 5'h01 : 5'h00);
  assign hop_edge = pins_s[3] & ~hop_d_r;
  assign commit_wr = WR_STB && (ADDR == `HTS_OFF_COMMIT);
  assign hop_ev   = (st_r == hts_pkg::HTS_RUN) && (hop_edge || commit_wr);
  assign ent      = mem[pos_nxt];

  // ----------------------------------------
  // next entry position
  // ----------------------------------------
  always_comb begin
    np = pos_r;
    case (op)
      hts_pkg::HTS_OP_PINGPONG: begin
        if (pos_r[2:0] == cur_last) begin
          np = {(pos_r[3] ? ld_a : ld_b) ? ~pos_r[3] : pos_r[3], 3'h0};
        end else begin
          np = {pos_r[3], pos_r[2:0] + 3'h1};
        end
      end
      hts_pkg::HTS_OP_GPIO: begin
        np = {run_tbl, pins_s[2:0]};
      end
      default: begin
        np = {pos_r[3], (pos_r[2:0] == cur_last) ? 3'h0 : pos_r[2:0] + 3'h1};
      end
    endcase
  end

  // ----------------------------------------
  // sequencer and register file next state
  // ----------------------------------------
  always_comb begin
    ctrl_nxt    = ctrl_r;
    len_nxt     = len_r;
    sel_nxt     = sel_r;
    pos_nxt     = pos_r;
    prep_nxt    = prep_r;
    cur_nxt     = cur_r;
    next_nxt    = next_r;
    osc0_nxt    = osc0_r;
    osc1_nxt    = osc1_r;
    sel_osc_nxt = sel_osc_r;
    app_nxt     = app_r;
    st_nxt      = st_r;
    retune_nxt  = 1'b0;
    hop_p_nxt   = 1'b0;
    rd_nxt      = 32'h0000_0000;

    if (WR_STB) begin
      if (ADDR == `HTS_OFF_CTRL) begin
        ctrl_nxt = WR_DATA[7:0];
      end else if (ADDR == `HTS_OFF_LEN) begin
        len_nxt = WR_DATA[6:0];
      end else if (ADDR == `HTS_OFF_SEL) begin
        sel_nxt = WR_DATA[3:0];
      end
    end

    if (RD_STB) begin
      if (ADDR == `HTS_OFF_CTRL) begin
        rd_nxt = {24'h00_0000, ctrl_r};
      end else if (ADDR == `HTS_OFF_LEN) begin
        rd_nxt = {25'h000_0000, len_r};
      end else if (ADDR == `HTS_OFF_SEL) begin
        rd_nxt = {28'h000_0000, sel_r};
      end else if (ADDR == `HTS_OFF_CARRIER) begin
        rd_nxt = mem[sel_r].carrier;
      end else if (ADDR == `HTS_OFF_RX1_OFS) begin
        rd_nxt = mem[sel_r].rx1_ofs;
      end else if (ADDR == `HTS_OFF_RX2_OFS) begin
        rd_nxt = mem[sel_r].rx2_ofs;
      end else if (ADDR == `HTS_OFF_GAINS) begin
        rd_nxt = {mem[sel_r].tx_atten, mem[sel_r].rx2_gain, mem[sel_r].rx1_gain};
      end else if (ADDR == `HTS_OFF_STATUS) begin
        rd_nxt = {16'h0000, prep_r, (st_r == hts_pkg::HTS_PREP), (st_r != hts_pkg::HTS_IDLE),
                  sel_osc_r, next_r, cur_r, pos_r};
      end
    end

    // frame pipeline shifts on every hop; a commit lands two frames out
    if (hop_ev) begin
      cur_nxt   = next_r;
      next_nxt  = commit_wr ? WR_DATA[`HTS_COMMIT_TX:`HTS_COMMIT_RX] : 2'h0;
      hop_p_nxt = 1'b1;
    end

    case (st_r)
      hts_pkg::HTS_IDLE: begin
        if (en && (ld_a || ld_b)) begin
          pos_nxt  = {run_tbl, 3'h0};
          prep_nxt = 5'h00;
          st_nxt   = (osc_mode == hts_pkg::HTS_OSC_PREPROC) ? hts_pkg::HTS_PREP : hts_pkg::HTS_PROC;
        end
      end
      hts_pkg::HTS_PREP: begin
        // every loaded entry is processed before the first hop
        if (prep_r + 5'h01 >= total) begin
          app_nxt     = ent;
          st_nxt      = hts_pkg::HTS_RUN;
          sel_osc_nxt = ~sel_osc_r;
          if (sel_osc_r) begin
            osc0_nxt = ent.carrier;
          end else begin
            osc1_nxt = ent.carrier;
          end
        end else begin
          prep_nxt = prep_r + 5'h01;
        end
      end
      hts_pkg::HTS_RUN: begin
        if (hop_ev) begin
          pos_nxt = np;
          if (osc_mode == hts_pkg::HTS_OSC_PREPROC) begin
            // standby oscillator takes the entry and is switched in at the hop
            app_nxt     = ent;
            sel_osc_nxt = ~sel_osc_r;
            if (sel_osc_r) begin
              osc0_nxt = ent.carrier;
            end else begin
              osc1_nxt = ent.carrier;
            end
          end else begin
            st_nxt = hts_pkg::HTS_PROC;
          end
        end
      end
      default: begin
        // processing costs one cycle; hops arriving now are not taken
        app_nxt = ent;
        st_nxt  = hts_pkg::HTS_RUN;
        if (osc_mode == hts_pkg::HTS_OSC_RETUNE) begin
          osc0_nxt    = ent.carrier;
          sel_osc_nxt = 1'b0;
          retune_nxt  = 1'b1;
        end else begin
          sel_osc_nxt = ~sel_osc_r;
          if (sel_osc_r) begin
            osc0_nxt = ent.carrier;
          end else begin
            osc1_nxt = ent.carrier;
          end
        end
      end
    endcase

    if (!en) begin
      st_nxt = hts_pkg::HTS_IDLE;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_r    <= `HTS_CTRL_RST;
      len_r     <= `HTS_LEN_RST;
      sel_r     <= `HTS_SEL_RST;
      pos_r     <= 4'h0;
      prep_r    <= 5'h00;
      cur_r     <= 2'h0;
      next_r    <= 2'h0;
      osc0_r    <= 32'h0000_0000;
      osc1_r    <= 32'h0000_0000;
      sel_osc_r <= 1'b0;
      retune_r  <= 1'b0;
      hop_p_r   <= 1'b0;
      rd_r      <= 32'h0000_0000;
      app_r     <= '0;
      st_r      <= hts_pkg::HTS_IDLE;
      hop_d_r   <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      len_r     <= len_nxt;
      sel_r     <= sel_nxt;
      pos_r     <= pos_nxt;
      prep_r    <= prep_nxt;
      cur_r     <= cur_nxt;
      next_r    <= next_nxt;
      osc0_r    <= osc0_nxt;
      osc1_r    <= osc1_nxt;
      sel_osc_r <= sel_osc_nxt;
      retune_r  <= retune_nxt;
      hop_p_r   <= hop_p_nxt;
      rd_r      <= rd_nxt;
      app_r     <= app_nxt;
      st_r      <= st_nxt;
      hop_d_r   <= pins_s[3];
    end
  end

  // table contents are not reset; software loads them before enabling
  always_ff @(posedge CLK) begin
    if (WR_STB) begin
      if (ADDR == `HTS_OFF_CARRIER) begin
        mem[sel_r].carrier <= WR_DATA;
      end else if (ADDR == `HTS_OFF_RX1_OFS) begin
        mem[sel_r].rx1_ofs <= WR_DATA;
      end else if (ADDR == `HTS_OFF_RX2_OFS) begin
        mem[sel_r].rx2_ofs <= WR_DATA;
      end else if (ADDR == `HTS_OFF_GAINS) begin
        mem[sel_r].rx1_gain <= WR_DATA[7:0];
        mem[sel_r].rx2_gain <= WR_DATA[15:8];
        mem[sel_r].tx_atten <= WR_DATA[31:16];
      end
    end
  end

  assign RD_DATA      = rd_r;
  assign CARRIER_FREQ = app_r.carrier;
  assign RX1_OFFSET   = app_r.rx1_ofs;
  assign RX2_OFFSET   = app_r.rx2_ofs;
  assign RX1_GAIN     = app_r.rx1_gain;
  assign RX2_GAIN     = app_r.rx2_gain;
  assign TX_ATTEN     = app_r.tx_atten;
  assign OSC0_FREQ    = osc0_r;
  assign OSC1_FREQ    = osc1_r;
  assign OSC_SEL      = sel_osc_r;
  assign RETUNE_PULSE = retune_r;
  assign HOP_PULSE    = hop_p_r;
  assign CUR_ASSIGN   = cur_r;
  assign NEXT_ASSIGN  = next_r;

endmodule
